// *** pkg/sbd_pkg.sv ***
// Function
// - unimplemented locations read zero, ignore writes
// - mirrored registers decode identically in every bank
// - upper counter bits only via holding latch
// - indirect port accesses memory at pointer address
// - reset encoding: x undefined, u kept, q cause
// - power-up values for pointer, timer0 and port b only on power-up or brown-out
package sbd_pkg;
   localparam logic [8:0] ADR_INDIRECT = 9'h100;
   localparam logic [8:0] ADR_TIMER0 = 9'h101;
   localparam logic [8:0] ADR_PC_LOW = 9'h102;
   localparam logic [8:0] ADR_STATUS = 9'h103;
   localparam logic [8:0] ADR_POINTER = 9'h104;
   localparam logic [8:0] ADR_PORT_B = 9'h106;
   localparam logic [8:0] ADR_PCHLATCH = 9'h10A;
   localparam logic [8:0] ADR_INTCTL = 9'h10B;
   localparam logic [8:0] ADR_INDIRECT3 = 9'h180;
   // unimplemented bank-two locations, all read as zero
   localparam int GAP_N = 8;
   localparam logic [8:0] GAP_ADR [GAP_N] = '{9'h105, 9'h107, 9'h108, 9'h109,
      9'h10C, 9'h10D, 9'h10E, 9'h10F};
   // low seven address bits select the location; mirrored ones ignore bank
   localparam logic [6:0] LOC_INDIRECT = 7'h00;
   localparam logic [6:0] LOC_PC_LOW = 7'h02;
   localparam logic [6:0] LOC_STATUS = 7'h03;
   localparam logic [6:0] LOC_POINTER = 7'h04;
   localparam logic [6:0] LOC_PCHLATCH = 7'h0A;
   localparam logic [6:0] LOC_INTCTL = 7'h0B;
   localparam logic [1:0] BANK2 = 2'h2;
   // power-up values (x bits taken as zero)
   localparam logic [7:0] POR_PC_LOW = 8'h00;
   localparam logic [7:0] POR_STATUS = 8'h18;
   localparam logic [7:0] POR_POINTER = 8'h00;
   localparam logic [7:0] POR_INTCTL = 8'h00;
   localparam logic [4:0] POR_PCHLATCH = 5'h00;
   localparam logic [7:0] POR_TIMER0 = 8'h00;
   localparam logic [7:0] POR_PORT_B = 8'h00;
   // other-reset: status keeps low three bits, q bits from cause inputs
   localparam logic [7:0] STATUS_KEEP_MASK = 8'h07;
   localparam int STATUS_TO_BIT = 4;
   localparam int STATUS_PD_BIT = 3;
   localparam int INTCTL_KEEP_BIT = 0;
   typedef enum logic [1:0] {
      RST_NONE = 2'b00,
      RST_POWER = 2'b01,
      RST_OTHER = 2'b10
   } sbd_rst_type;
endpackage

// *** hw/sbd_bank.sv ***
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module sbd_bank
   import sbd_pkg::*;
#(
   // sizes; the decode tables are fixed to the documented widths
   parameter int DATA_W = 8,
   parameter int ADDR_W = 9,
   parameter int PCH_W = 5
)
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // reset cause: power-up/brown-out vs pin/watchdog
   input wire logic POWER_RESET,
   input wire logic TIMEOUT_FLAG,
   input wire logic POWERDOWN_FLAG,
   // register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [DATA_W-1:0] RDATA,
   // indirect data memory port
   output logic [ADDR_W-1:0] MEM_ADDR,
   output logic [DATA_W-1:0] MEM_WDATA,
   output logic MEM_WR,
   input wire logic [DATA_W-1:0] MEM_RDATA,
   // port b pins
   input wire logic [DATA_W-1:0] PORT_B_PINS,
   output logic [DATA_W-1:0] PORT_B_LATCH,
   // program counter
   input wire logic PC_LOAD,
   output logic [PCH_W+DATA_W-1:0] PC_VALUE
);
   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks: package addresses and masks assume these sizes
   generate
      if (DATA_W != 8) begin : g_bad_data
         $error("data width must be 8");
      end
      if (ADDR_W != 9) begin : g_bad_addr
         $error("address width must be 9");
      end
      if (PCH_W != 5) begin : g_bad_pch
         $error("upper counter width must be 5");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // all state in one word; rdata is the registered read answer
   typedef struct packed {
      logic [DATA_W-1:0] timer0_count;
      logic [DATA_W-1:0] pc_low;
      logic [PCH_W-1:0] pc_high;
      logic [DATA_W-1:0] status;
      logic [DATA_W-1:0] pointer;
      logic [DATA_W-1:0] port_b_latch;
      logic [PCH_W-1:0] pch_latch;
      logic [DATA_W-1:0] intctl;
      logic [DATA_W-1:0] rdata;
   } sbd_state_type;

   sbd_state_type st_r;
   sbd_state_type st_nxt;
   sbd_rst_type rst_cause;

   ////////////////////////////////////////////////////////////////////////////
   // decodes mirrored location regardless of bank
   function automatic logic hit_loc(input logic [8:0] a, input logic [6:0] loc);
      return a[6:0] == loc;
   endfunction

   // bank-two-only location: timer and port b are not mirrored
   function automatic logic hit_b2(input logic [8:0] a, input logic [8:0] full);
      return a == full;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // address decode, shared by the write and the read path
   logic ind_hit;
   logic pc_low_hit;
   logic status_hit;
   logic pointer_hit;
   logic pch_hit;
   logic intctl_hit;
   logic timer_hit;
   logic port_b_hit;
   assign ind_hit = hit_loc(ADDR, LOC_INDIRECT);
   assign pc_low_hit = hit_loc(ADDR, LOC_PC_LOW);
   assign status_hit = hit_loc(ADDR, LOC_STATUS);
   assign pointer_hit = hit_loc(ADDR, LOC_POINTER);
   assign pch_hit = hit_loc(ADDR, LOC_PCHLATCH);
   assign intctl_hit = hit_loc(ADDR, LOC_INTCTL);
   assign timer_hit = hit_b2(ADDR, ADR_TIMER0);
   assign port_b_hit = hit_b2(ADDR, ADR_PORT_B);

   ////////////////////////////////////////////////////////////////////////////
   // reset cause: pin and watchdog share the other-reset column
   always_comb begin
      rst_cause = RST_NONE;
      if (SYS_RST) begin
         if (POWER_RESET) begin
            rst_cause = RST_POWER;
         end else begin
            rst_cause = RST_OTHER;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // indirect memory port: pointer drives address, no physical register
   assign MEM_ADDR = {{(ADDR_W-DATA_W){1'b0}}, st_r.pointer};
   assign MEM_WDATA = WDATA;
   assign MEM_WR = WR_STB && ind_hit;
   // outputs straight from the state word
   assign RDATA = st_r.rdata;
   assign PORT_B_LATCH = st_r.port_b_latch;
   assign PC_VALUE = {st_r.pc_high, st_r.pc_low};

   ////////////////////////////////////////////////////////////////////////////
   // next state: writes, read mux, reset columns
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 8'h00;
      // a counter load copies the latch into the upper bits
      if (PC_LOAD) begin
         st_nxt.pc_high = st_r.pch_latch;
      end
      if (WR_STB) begin
         if (pc_low_hit) begin
            st_nxt.pc_low = WDATA;
            st_nxt.pc_high = st_r.pch_latch;
         end
         // to and pd bits are not writable
         if (status_hit) begin
            st_nxt.status = {WDATA[7:5], st_r.status[4:3], WDATA[2:0]};
         end
         if (pointer_hit) begin
            st_nxt.pointer = WDATA;
         end
         if (pch_hit) begin
            st_nxt.pch_latch = WDATA[4:0];
         end
         if (intctl_hit) begin
            st_nxt.intctl = WDATA;
         end
         if (timer_hit) begin
            st_nxt.timer0_count = WDATA;
         end
         if (port_b_hit) begin
            st_nxt.port_b_latch = WDATA;
         end
         // any other address falls through: write ignored
      end
      // reads: indirect data is taken from memory in the strobe cycle
      if (RD_STB) begin
         if (ind_hit) begin
            st_nxt.rdata = MEM_RDATA;
         end else if (pc_low_hit) begin
            st_nxt.rdata = st_r.pc_low;
         end else if (status_hit) begin
            st_nxt.rdata = st_r.status;
         end else if (pointer_hit) begin
            st_nxt.rdata = st_r.pointer;
         end else if (pch_hit) begin
            st_nxt.rdata = {3'h0, st_r.pch_latch};
         end else if (intctl_hit) begin
            st_nxt.rdata = st_r.intctl;
         end else if (timer_hit) begin
            st_nxt.rdata = st_r.timer0_count;
         end else if (port_b_hit) begin
            st_nxt.rdata = PORT_B_PINS;
         end
      end
      // reset columns; x bits cleared, u bits kept
      case (rst_cause)
         RST_POWER: begin
            st_nxt.rdata = 8'h00;
            st_nxt.pc_low = POR_PC_LOW;
            st_nxt.pc_high = 5'h00;
            st_nxt.pch_latch = POR_PCHLATCH;
            st_nxt.status = POR_STATUS;
            st_nxt.pointer = POR_POINTER;
            st_nxt.intctl = POR_INTCTL;
            st_nxt.timer0_count = POR_TIMER0;
            st_nxt.port_b_latch = POR_PORT_B;
         end
         RST_OTHER: begin
            st_nxt.rdata = 8'h00;
            st_nxt.pc_low = POR_PC_LOW;
            st_nxt.pc_high = 5'h00;
            st_nxt.pch_latch = POR_PCHLATCH;
            st_nxt.status = st_r.status & STATUS_KEEP_MASK;
            st_nxt.status[STATUS_TO_BIT] = TIMEOUT_FLAG;
            st_nxt.status[STATUS_PD_BIT] = POWERDOWN_FLAG;
            st_nxt.intctl = {7'h00, st_r.intctl[INTCTL_KEEP_BIT]};
         end
         RST_NONE: begin
            // no reset: the writes and reads above stand
            st_nxt.rdata = st_nxt.rdata;
         end
         default: begin
            st_nxt = st_r;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // single state register; reset is folded into the next-state logic
   always_ff @(posedge REF_CLK) begin
      st_r <= st_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // first gap of the bank reads zero
   AST_GAP_ZERO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      RD_STB && ADDR == 9'h105 |=> RDATA == 8'h00)
      else $error("gap location read nonzero");

   // last gap of the bank never reaches the port latch
   AST_GAP_NOWRITE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      WR_STB && ADDR[6:0] == 7'h0F && ADDR[8:7] == BANK2 |=> $stable(PORT_B_LATCH))
      else $error("gap write changed state");

   // pointer written through any bank steers the memory address
   AST_MIRROR_PTR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      WR_STB && pointer_hit |=> MEM_ADDR[7:0] == $past(WDATA))
      else $error("pointer mirror failed");

   // latch reaches the upper counter bits on a load
   AST_PC_LOAD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      WR_STB && pch_hit ##1 PC_LOAD && !WR_STB
      |=> PC_VALUE[12:8] == $past(WDATA[4:0], 2))
      else $error("latch not copied to pc");

   // a write to the low byte pulls the latch along with it
   AST_PC_LOW_WR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      WR_STB && pc_low_hit |=> PC_VALUE == {$past(st_r.pch_latch), $past(WDATA)})
      else $error("low byte write lost latch");

   // indirect writes go only to memory, at the pointer
   AST_IND_WR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      MEM_WR |-> MEM_ADDR == {1'b0, st_r.pointer} && ind_hit)
      else $error("indirect write misdirected");

   // indirect reads hand back the memory word
   AST_IND_RD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      RD_STB && ind_hit |=> RDATA == $past(MEM_RDATA))
      else $error("indirect read wrong");

   // other reset keeps the undefined-at-power-up enable bit
   AST_OTHER_RST: assert property (@(posedge REF_CLK)
      SYS_RST && !POWER_RESET |=> RDATA == 8'h00 && st_r.intctl[0] == $past(st_r.intctl[0]))
      else $error("kept bit lost on reset");

   // power-up column for status
   AST_POR_STATUS: assert property (@(posedge REF_CLK)
      SYS_RST && POWER_RESET |=> st_r.status == POR_STATUS)
      else $error("power-up status wrong");

   // power-up column for interrupt control, x bit taken as zero
   AST_POR_INTCTL: assert property (@(posedge REF_CLK)
      SYS_RST && POWER_RESET |=> st_r.intctl == POR_INTCTL)
      else $error("power-up interrupt control wrong");

   // port reads show pins, not the latch
   AST_PORT_B: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      RD_STB && port_b_hit |=> RDATA == $past(PORT_B_PINS))
      else $error("port read not pins");

   // port writes land in the latch
   AST_PORT_B_WR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      WR_STB && port_b_hit |=> PORT_B_LATCH == $past(WDATA))
      else $error("port write missed latch");

   // to and pd survive a status write
   AST_STATUS_RO: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      WR_STB && status_hit |=> st_r.status[4:3] == $past(st_r.status[4:3]))
      else $error("status reset bits written");

   // per-gap checks over every unimplemented bank-two location
   for (genvar g = 0; g < GAP_N; g++) begin : g_gap
      AST_GAP_RD: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
         RD_STB && ADDR == GAP_ADR[g] |=> RDATA == 8'h00)
         else $error("gap read nonzero");
      AST_GAP_WR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
         WR_STB && ADDR == GAP_ADR[g] && !PC_LOAD
         |=> $stable(st_r.pointer) && $stable(st_r.status) && $stable(st_r.intctl)
            && $stable(st_r.timer0_count) && $stable(st_r.port_b_latch)
            && $stable(st_r.pch_latch) && $stable(PC_VALUE))
         else $error("gap write changed a register");
   end

   // main scenarios
   COV_IND_WR: cover property (@(posedge REF_CLK) MEM_WR);
   COV_PC_LOAD: cover property (@(posedge REF_CLK) PC_LOAD && st_r.pch_latch != 5'h00);
   COV_OTHER_RST: cover property (@(posedge REF_CLK) SYS_RST && !POWER_RESET);
   COV_POWER_RST: cover property (@(posedge REF_CLK) SYS_RST && POWER_RESET);
   COV_PORT_B_RD: cover property (@(posedge REF_CLK) RD_STB && port_b_hit);
endmodule

// *** verification/sbd_bank_tb.sv ***
`timescale 1ns/1ns
module tb;
   ////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic power_reset = 1'b1;
   logic timeout_flag = 1'b0;
   logic powerdown_flag = 1'b0;
   logic [8:0] addr = 9'h000;
   logic [7:0] wdata = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [7:0] mem_rdata = 8'h00;
   logic [7:0] port_b_pins = 8'h00;
   logic pc_load = 1'b0;
   logic [7:0] rdata;
   logic [7:0] mem_wdata;
   logic [7:0] port_b_latch;
   logic [8:0] mem_addr;
   logic mem_wr;
   logic [12:0] pc_value;
   int num_errors = 0;
   int check_count = 0;
   // unimplemented bank-two locations; the gap test writes 8'hFF to each and reads it back as zero
   localparam logic [8:0] GAPS [8] = '{9'h105, 9'h107, 9'h108, 9'h109, 9'h10C, 9'h10D,
      9'h10E, 9'h10F};
   sbd_bank sbd_bank_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .POWER_RESET(power_reset),
      .TIMEOUT_FLAG(timeout_flag), .POWERDOWN_FLAG(powerdown_flag), .ADDR(addr),
      .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .MEM_ADDR(mem_addr),
      .MEM_WDATA(mem_wdata), .MEM_WR(mem_wr), .MEM_RDATA(mem_rdata),
      .PORT_B_PINS(port_b_pins), .PORT_B_LATCH(port_b_latch), .PC_LOAD(pc_load),
      .PC_VALUE(pc_value));
   // 250 MHz core clock
   always #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////
   // shared tasks; case inequality so unknowns never match
   task chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task do_reset(input logic pwr);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      power_reset <= pwr;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
   endtask
   task wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 chk("read data", {5'h00, rdata}, {5'h00, exp});
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task test_power_reset;
      rd(9'h103, sbd_pkg::POR_STATUS);
      rd(9'h104, 8'h00);
      rd(9'h10B, 8'h00);
      rd(9'h10A, 8'h00);
      $display("power reset test done");
   endtask
   task test_gaps;
      foreach (GAPS[i]) begin
         wr(GAPS[i], 8'hFF);
         rd(GAPS[i], 8'h00);
      end
      $display("gap test done");
   endtask
   task test_mirror;
      wr(9'h104, 8'h5A);
      rd(9'h004, 8'h5A);
      rd(9'h184, 8'h5A);
      wr(9'h08A, 8'h15);
      rd(9'h10A, 8'h15);
      $display("mirror test done");
   endtask
   task test_indirect;
      @(posedge ref_clk);
      wr_stb <= 1'b1;
      addr <= 9'h100;
      wdata <= 8'h33;
      #1 chk("mem write", {4'h0, mem_wr, mem_wdata}, 13'h0133);
      chk("mem addr", {4'h0, mem_addr}, 13'h005A);
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      mem_rdata <= 8'hC3;
      rd(9'h180, 8'hC3);
      $display("indirect test done");
   endtask
   task test_pc;
      @(posedge ref_clk);
      pc_load <= 1'b1;
      @(posedge ref_clk);
      pc_load <= 1'b0;
      #1 chk("pc value", pc_value, 13'h1500);
      wr(9'h002, 8'h34);
      #1 chk("pc after low write", pc_value, 13'h1534);
      rd(9'h102, 8'h34);
      $display("program counter test done");
   endtask
   task test_port_b;
      port_b_pins <= 8'h3C;
      wr(9'h106, 8'hA5);
      #1 chk("port latch", {5'h00, port_b_latch}, 13'h00A5);
      rd(9'h106, 8'h3C);
      $display("port test done");
   endtask
   // pin or watchdog reset keeps what power-up would clear
   task test_other_reset;
      wr(9'h103, 8'h05);
      rd(9'h103, 8'h1D);
      wr(9'h10B, 8'h01);
      wr(9'h101, 8'h77);
      rd(9'h101, 8'h77);
      timeout_flag <= 1'b1;
      do_reset(1'b0);
      rd(9'h103, 8'h15);
      rd(9'h10B, 8'h01);
      rd(9'h104, 8'h5A);
      rd(9'h101, 8'h77);
      chk("latch kept", {5'h00, port_b_latch}, 13'h00A5);
      // second cause: power-down flag alone
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b1;
      do_reset(1'b0);
      rd(9'h103, 8'h0D);
      $display("other reset test done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      do_reset(1'b1);
      test_power_reset();
      test_gaps();
      test_mirror();
      test_indirect();
      test_pc();
      test_port_b();
      test_other_reset();
      summarize();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      num_errors++;
      summarize();
   end
endmodule
